// >>> tws_pkg.sv
// Package of constants and types for the two-wire slave block.
// Operation
// - General-call data ack follows ack_enable.
// - Not-acked general-call data ends addressed operation.
// - Stop or restart while addressed reports 0xA0.
// - Idle mode recognition gated by ack_enable, general_call_enable.
// - Pending begin request makes START when free.
// - Status code valid with prescaler bits masked.
// - Upper own_address_reg bits hold slave address.
// - general_call_enable allows general call address 0x00.
// - Addresses acknowledged only while ack_enable set.
// - Direction bit selects transmit or receive.
// - Address match sets irq_flag and status.
// - Lost arbitration, read address reports 0xB0.
// - Cleared ack_enable sends last byte, 0xC0/0xC8.
// - After last byte, release data, ignore clocks.
// - Cleared ack_enable isolates, bus still monitored.
// - Address match in clock-stopped sleep wakes system.
// - Clock held low after wake until flag cleared.
// - data_reg need not hold byte after wake.
// - Status 0xA8: send loaded byte, ack per ack_enable.
// - Status 0xB8: next byte last unless ack_enable.
`default_nettype none
package tws_pkg;
	// Word-aligned byte offsets of the registers on the APB.
	localparam logic [3:0] ADDR_OWN = 4'h0;
	localparam logic [3:0] ADDR_CTL = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_DATA = 4'hC;
	// Bit positions inside control_reg.
	localparam int CB_IRQ = 7;
	localparam int CB_ACK = 6;
	localparam int CB_BEG = 5;
	localparam int CB_HALT = 4;
	localparam int CB_WCOL = 3;
	localparam int CB_ON = 2;
	localparam int CB_RSV = 1;
	localparam int CB_IE = 0;
	// Bit position of general_call_enable inside own_address_reg.
	localparam int OB_GCE = 0;
	// Reset values of the registers.
	localparam logic [7:0] OWN_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'hFF;
	// Status codes with the prescaler bits at zero.
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_OWN_W = 8'h60;
	localparam logic [7:0] ST_GC_W = 8'h70;
	localparam logic [7:0] ST_RX_ACK = 8'h80;
	localparam logic [7:0] ST_RX_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_STOP = 8'hA0;
	localparam logic [7:0] ST_OWN_R = 8'hA8;
	localparam logic [7:0] ST_ARB_R = 8'hB0;
	localparam logic [7:0] ST_TX_ACK = 8'hB8;
	localparam logic [7:0] ST_TX_NACK = 8'hC0;
	localparam logic [7:0] ST_TX_LAST = 8'hC8;
	localparam logic [7:0] ST_NONE = 8'hF8;
	// Mask that splits the status register into code and prescaler, and the prescaler reset value.
	localparam logic [7:0] CODE_MASK = 8'hF8;
	localparam logic [1:0] PRESC_RST = 2'h0;
	// The general call address and the bit count of one byte.
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [3:0] BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	// Least hold time of a generated START, and its count in clocks.
	localparam int CLK_NS = 8;
	localparam int T_START_NS = 4000;
	localparam int START_CYC = (T_START_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] HOLD_END = 10'(START_CYC - 1);
	// Bus-side states of the slave engine.
	typedef enum logic [3:0] {
		S_IDLE, S_START, S_ADDR, S_AACK, S_TXW, S_TX, S_TACK, S_RX, S_RACK
	} tws_state_type;
endpackage
`default_nettype wire

// >>> tws_line_mon.sv
// Synchroniser and condition detector for the two bus lines.
`default_nettype none
module tws_line_mon (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_p,
	output logic stop_p,
	output logic bus_free
);
	// First and second stages of the synchronisers.
	logic scl_m_q, sda_m_q, scl_q, sda_q;
	// Delayed copies used only for edge detection.
	logic scl_d1_q, sda_d1_q;
	// Bus is free between a STOP and the next START.
	logic free_q;

	// Two flip-flops per line before any logic reads the level.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_m_q <= 1'b1;
			sda_m_q <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			sda_m_q <= sda_i;
			scl_q <= scl_m_q;
			sda_q <= sda_m_q;
			scl_d1_q <= scl_q;
			sda_d1_q <= sda_q;
		end
	end

	// Edges of the clock line, seen on the system clock.
	assign scl_s = scl_q;
	assign sda_s = sda_q;
	assign scl_rise = scl_q & ~scl_d1_q;
	assign scl_fall = ~scl_q & scl_d1_q;
	// A data edge while the clock is high marks START or STOP.
	assign start_p = scl_q & scl_d1_q & sda_d1_q & ~sda_q;
	assign stop_p = scl_q & scl_d1_q & ~sda_d1_q & sda_q;
	assign bus_free = free_q;

	// Tracks whether another master holds the bus.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			free_q <= 1'b1;
		end else if (start_p) begin
			free_q <= 1'b0;
		end else if (stop_p) begin
			free_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tws_slave.sv
// Two-wire slave engine with its APB register file.
//
// Local design decisions: the placing of the registers and the APB register port.
`default_nettype none
module tws_slave
	import tws_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [3:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic clk_stopped,
	input wire logic arb_lost,
	output logic wake
);
	// Synchronised bus levels and detected events.
	logic scl_s, sda_s, scl_rise, scl_fall, start_p, stop_p, bus_free;
	// Software-visible registers.
	logic [7:0] own_q, ctl_q, ctl_d, code_q, code_d, data_q;
	logic [1:0] presc_q;
	// Engine state, shift register and bit counter.
	tws_state_type st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	// Addressed by general call, last byte, sampled or own ack.
	logic gc_q, gc_d, last_q, last_d, mack_q, mack_d;
	// Remembers lost arbitration until the ack of the address byte.
	logic arb_q;
	// Hold counter for a generated START.
	logic [9:0] hold_q, hold_d;
	// Engine pulses toward the register file.
	logic set_irq, beg_clr, dat_ld;
	// Registered outputs.
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, scl_oe_q, sda_oe_q, wake_q, low_q;

	// Line synchroniser and START/STOP detector.
	tws_line_mon u_mon (
		.clk(clk),
		.rst(rst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_p(start_p),
		.stop_p(stop_p),
		.bus_free(bus_free)
	);

	// APB decode; an access completes when pready is seen high.
	wire acc = psel & penable & pready_q;
	wire wr = acc & pwrite;
	wire sel_own = paddr == ADDR_OWN;
	wire sel_ctl = paddr == ADDR_CTL;
	wire sel_stat = paddr == ADDR_STAT;
	wire sel_data = paddr == ADDR_DATA;
	wire mapped = sel_own | sel_ctl | sel_stat | sel_data;
	wire [7:0] wd = pwdata[7:0];
	wire wr_ctl = wr & sel_ctl;
	wire wr_data = wr & sel_data;
	wire irq = ctl_q[CB_IRQ];
	wire on = ctl_q[CB_ON];
	wire ack_en = ctl_q[CB_ACK];
	wire irq_clr = wr_ctl & wd[CB_IRQ];
	// A one written to a set flag lets the engine go on.
	wire resume = irq & irq_clr;
	// A halt request with the flag clear drops to idle.
	wire halt_go = irq_clr & wd[CB_HALT];

	// Status shows 0xF8 while no event is pending.
	wire [7:0] code_rd = irq ? code_q : ST_NONE;
	wire [7:0] stat_rd = (code_rd & CODE_MASK) | {6'h00, presc_q};
	wire [7:0] rd8 = sel_own ? own_q :
		sel_ctl ? ctl_q :
		sel_stat ? stat_rd :
		sel_data ? data_q : 8'h00;

	// Address byte checks against own_address_reg.
	wire addr_own = sh_q[7:1] == own_q[7:1];
	wire addr_gc = (sh_q[7:1] == GC_ADDR) & own_q[OB_GCE] & ~sh_q[0];
	wire addr_end = (st_q == S_ADDR) & scl_fall & (cnt_q == BITS);
	// Matches only while ack_enable is set.
	wire hit = addr_end & ack_en & (addr_own | addr_gc);
	wire addressed = st_q inside {S_AACK, S_TXW, S_TX, S_TACK, S_RX,
		S_RACK};
	// Data drive: low for ack, low for a zero data bit, low for START.
	wire sda_drv = (st_q == S_AACK) | (st_q == S_START) |
		((st_q == S_RACK) & mack_q) | ((st_q == S_TX) & ~sh_q[7]);

	// Next value of control_reg; hardware sets win over clears.
	wire [7:0] ctl_w = wr_ctl ? wd : ctl_q;
	always_comb begin
		ctl_d = ctl_w;
		ctl_d[CB_IRQ] = set_irq | (irq & ~irq_clr);
		ctl_d[CB_BEG] = ctl_w[CB_BEG] & ~beg_clr;
		ctl_d[CB_HALT] = ctl_w[CB_HALT] & ~irq_clr;
		ctl_d[CB_WCOL] = (wr_data & ~irq) |
			(ctl_w[CB_WCOL] & ~(wr_data & irq));
		ctl_d[CB_RSV] = 1'b0;
	end

	// Bus engine: one transition per detected bus event.
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		code_d = code_q;
		gc_d = gc_q;
		last_d = last_q;
		mack_d = mack_q;
		hold_d = hold_q;
		set_irq = 1'b0;
		beg_clr = 1'b0;
		dat_ld = 1'b0;
		if (!on) begin
			// A disabled interface releases both lines.
			st_d = S_IDLE;
		end else if (st_q == S_START) begin
			// Hold data low, then report the START.
			hold_d = hold_q + 10'h001;
			if (hold_q == HOLD_END) begin
				st_d = S_IDLE;
				beg_clr = 1'b1;
				code_d = ST_START;
				set_irq = 1'b1;
			end
		end else if (halt_go) begin
			st_d = S_IDLE;
		end else if (start_p | stop_p) begin
			// Stop or restart ends an addressed transfer.
			if (addressed) begin
				code_d = ST_STOP;
				set_irq = 1'b1;
			end
			st_d = start_p ? S_ADDR : S_IDLE;
			cnt_d = 4'h0;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					// Begin request waits for a free bus.
					if (ctl_q[CB_BEG] & bus_free & ~irq) begin
						st_d = S_START;
						hold_d = 10'h000;
					end
				end
				S_START: begin
				end
				S_ADDR: begin
					// Address is shifted in even when isolated.
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (addr_end) begin
						st_d = hit ? S_AACK : S_IDLE;
						gc_d = ~addr_own;
						cnt_d = 4'h0;
					end
				end
				S_AACK: begin
					// End of the address ack clock.
					if (scl_fall) begin
						set_irq = 1'b1;
						if (sh_q[0]) begin
							code_d = arb_q ? ST_ARB_R : ST_OWN_R;
							st_d = S_TXW;
						end else begin
							code_d = gc_q ? ST_GC_W : ST_OWN_W;
							st_d = S_RX;
						end
					end
				end
				S_TXW: begin
					// Loaded byte goes out once the flag is cleared.
					if (resume) begin
						sh_d = data_q;
						// The ack_enable written with the clear decides.
						last_d = ~ctl_w[CB_ACK];
						cnt_d = 4'h0;
						st_d = S_TX;
					end
				end
				S_TX: begin
					if (scl_fall) begin
						sh_d = {sh_q[6:0], 1'b1};
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == LAST_BIT) begin
							st_d = S_TACK;
						end
					end
				end
				S_TACK: begin
					// Sample the master's answer, report at the fall.
					if (scl_rise) begin
						mack_d = ~sda_s;
					end else if (scl_fall) begin
						set_irq = 1'b1;
						if (!mack_q) begin
							code_d = ST_TX_NACK;
							st_d = S_IDLE;
						end else if (last_q) begin
							code_d = ST_TX_LAST;
							st_d = S_IDLE;
						end else begin
							code_d = ST_TX_ACK;
							st_d = S_TXW;
						end
					end
				end
				S_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall & (cnt_q == BITS)) begin
						mack_d = ack_en;
						cnt_d = 4'h0;
						st_d = S_RACK;
					end
				end
				S_RACK: begin
					// After a not-acked byte the slave is unaddressed.
					if (scl_fall) begin
						set_irq = 1'b1;
						dat_ld = ~clk_stopped;
						if (gc_q) begin
							code_d = mack_q ? ST_GC_ACK : ST_GC_NACK;
						end else begin
							code_d = mack_q ? ST_RX_ACK : ST_RX_NACK;
						end
						st_d = mack_q ? S_RX : S_IDLE;
					end
				end
			endcase
		end
	end

	// APB answer registers; one wait state on every access.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
			prdata_q <= {24'h00_0000, rd8};
		end
	end

	// Software registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			own_q <= OWN_RST;
			ctl_q <= CTL_RST;
			presc_q <= PRESC_RST;
			data_q <= DATA_RST;
		end else begin
			ctl_q <= ctl_d;
			if (wr & sel_own) begin
				own_q <= wd;
			end
			if (wr & sel_stat) begin
				presc_q <= wd[1:0];
			end
			if (dat_ld) begin
				data_q <= sh_q;
			end else if (wr_data & irq) begin
				data_q <= wd;
			end
		end
	end

	// Engine registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			code_q <= ST_NONE;
			gc_q <= 1'b0;
			last_q <= 1'b0;
			mack_q <= 1'b0;
			hold_q <= 10'h000;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
			gc_q <= gc_d;
			last_q <= last_d;
			mack_q <= mack_d;
			hold_q <= hold_d;
		end
	end

	// Pin drive, lost-arbitration memory and the wake level.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			wake_q <= 1'b0;
			arb_q <= 1'b0;
			low_q <= 1'b0;
		end else begin
			low_q <= 1'b0;
			// Clock stays low while the flag is set.
			scl_oe_q <= on & ctl_d[CB_IRQ];
			sda_oe_q <= on & sda_drv;
			// Wake stands until the system clock runs again.
			wake_q <= (hit & clk_stopped) | (wake_q & clk_stopped);
			// Kept through the address ack, where the code is chosen.
			arb_q <= arb_lost | (arb_q & (st_d != S_IDLE) &
				~((st_q == S_AACK) & scl_fall));
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign scl_o = low_q;
	assign sda_o = low_q;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign wake = wake_q;

	// Checks kept beside the logic they guard.
	AST_STRETCH: assert property (@(posedge clk) disable iff (rst)
		on && irq && !irq_clr |=> scl_oe_q)
		else $error("clock not held low while flag set");
	AST_STOP_A0: assert property (@(posedge clk) disable iff (rst)
		on && stop_p && addressed && !halt_go |=> irq && code_q == ST_STOP
		&& st_q == S_IDLE)
		else $error("stop while addressed not reported as 0xA0");
	AST_ISOLATE: assert property (@(posedge clk) disable iff (rst)
		on && addr_end && !ack_en && !start_p && !stop_p |=> st_q == S_IDLE)
		else $error("address acknowledged with ack_enable clear");
	AST_LAST_C8: assert property (@(posedge clk) disable iff (rst)
		on && st_q == S_TACK && scl_fall && mack_q && last_q && !halt_go
		|=> code_q == ST_TX_LAST && irq)
		else $error("acked last byte not reported as 0xC8");
	AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
		st_q == S_IDLE |=> !sda_oe_q)
		else $error("data line driven while unaddressed");
	AST_GC_GATE: assert property (@(posedge clk) disable iff (rst)
		st_q == S_ADDR && st_d == S_AACK && !addr_own |-> own_q[OB_GCE])
		else $error("general call taken while disabled");
	AST_START_GEN: assert property (@(posedge clk) disable iff (rst)
		st_q == S_IDLE && st_d == S_START |=> ##1 sda_oe_q ##[490:510]
		!sda_oe_q)
		else $error("generated start hold time wrong");
	AST_WAKE: assert property (@(posedge clk) disable iff (rst)
		hit && clk_stopped |=> wake)
		else $error("address match in sleep did not wake");
	AST_WAKE_LOW: assert property (@(posedge clk) disable iff (rst)
		on && wake && irq && !irq_clr |=> scl_oe_q)
		else $error("clock not held low after wake");
	AST_GC_NACK: assert property (@(posedge clk) disable iff (rst)
		on && st_q == S_RACK && scl_fall && gc_q && !mack_q && !halt_go
		&& !start_p && !stop_p |=> code_q == ST_GC_NACK && st_q == S_IDLE)
		else $error("not-acked general call data handled wrong");
endmodule
`default_nettype wire

// >>> tws_bus_master.sv
// Behavioural two-wire bus master that drives the clock line.
`default_nettype none
module tws_bus_master (
	input wire logic clk,
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_oe,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Count of clock-stretch waits that never ended.
	int hangs;
	// Both lines start released, so the pull-ups hold them high.
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		hangs = 0;
	end
	// Waits a number of system clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Releases the clock and waits while the slave stretches it.
	task automatic rel_scl();
		int n;
		n = 0;
		scl_oe <= 1'b0;
		tick(1);
		while (scl_w !== 1'b1 && n < 5000) begin
			tick(1);
			n++;
		end
		if (n >= 5000) begin
			hangs++;
		end
	endtask
	// Data may change only while the clock is low.
	task automatic bit_slot(input logic b, output logic s);
		tick(2);
		sda_oe <= ~b;
		tick(3);
		rel_scl();
		tick(4);
		s = sda_w;
		scl_oe <= 1'b1;
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		tick(2);
		sda_oe <= 1'b0;
		tick(3);
		rel_scl();
		tick(5);
		sda_oe <= 1'b1;
		tick(5);
		scl_oe <= 1'b1;
	endtask
	// Stop: data rises while the clock is high, then all is released.
	task automatic stop();
		tick(2);
		sda_oe <= 1'b1;
		tick(3);
		rel_scl();
		tick(5);
		sda_oe <= 1'b0;
		tick(5);
	endtask
	// One byte, most significant bit first, then the answer bit.
	task automatic xfer(input logic [7:0] d, input logic ab,
		output logic [7:0] q, output logic ag);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], s);
			q[i] = s;
		end
		bit_slot(ab, ag);
	endtask
endmodule
`default_nettype wire

// >>> two_wire_slave_rx_tx_tb.sv
// Self-checking bench for the two-wire slave block.
`default_nettype none
module two_wire_slave_rx_tx_tb
	import tws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, clk_stopped, arb_lost;
	logic [3:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, scl_oe, sda_oe, wake, m_scl_oe, m_sda_oe;
	logic scl_o, sda_o;
	logic [15:0] seed;
	logic [7:0] q, d;
	logic [6:0] own;
	logic a, e;
	int miscompares, total_checks;
	// Both lines are open drain with pull-ups; the slave drives its level.
	wire logic scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl_oe;
	wire logic sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda_oe;
	tws_slave u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_i(scl_w), .scl_o,
		.scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .clk_stopped,
		.arb_lost, .wake);
	tws_bus_master u_master (.clk, .scl_w, .sda_w, .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe));
	// System clock of 8 ns.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Xorshift source of repeatable stimulus.
	function automatic logic [15:0] xs();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed;
	endfunction
	// Compares one byte and counts the result.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the access phase lasts until pready.
	task automatic apb(input logic w, input logic [3:0] ad,
		input logic [7:0] wd, output logic [7:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// A transfer that never completes counts as a mismatch.
		if (pready !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED %0t no pready", $time);
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] x);
		logic [7:0] v;
		logic er;
		apb(1'b0, ad, 8'h00, v, er);
		chk(v, x);
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
		logic [7:0] v;
		logic er;
		apb(1'b1, ad, wd, v, er);
	endtask
	// Polls control_reg until irq_flag is set, with a bound.
	task automatic wait_irq();
		logic [7:0] v;
		logic er;
		int n;
		n = 0;
		do begin
			apb(1'b0, ADDR_CTL, 8'h00, v, er);
			n++;
		end while (v[CB_IRQ] !== 1'b1 && n < 400);
		chk(8'(v[CB_IRQ]), 8'h01);
	endtask
	// Start plus address byte; optional lost arbitration meanwhile.
	task automatic sel(input logic [7:0] b, input logic arb,
		input logic ack, input logic [7:0] st);
		logic [7:0] v;
		logic ag;
		u_master.start();
		if (arb) begin
			arb_lost <= 1'b1;
			@(posedge clk);
			arb_lost <= 1'b0;
		end
		u_master.xfer(b, 1'b1, v, ag);
		chk(8'(ag), {7'h00, ~ack});
		if (ack) begin
			wait_irq();
			rd(ADDR_STAT, st);
			chk(8'(scl_oe), 8'h01);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (miscompares == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake.
	initial begin
		#400000;
		miscompares++;
		wrap_up();
	end
	// Main sequence.
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h00000000;
		clk_stopped = 1'b0;
		arb_lost = 1'b0;
		seed = 16'h6D4D;
		miscompares = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_OWN, OWN_RST);
		rd(ADDR_CTL, CTL_RST);
		rd(ADDR_DATA, DATA_RST);
		rd(ADDR_STAT, ST_NONE);
		apb(1'b0, 4'h6, 8'h00, q, e);
		chk(q, 8'h00);
		chk(8'(e), 8'h01);
		own = 7'h40 | 7'(xs() & 16'h003F);
		wr(ADDR_OWN, {own, 1'b1});
		wr(ADDR_CTL, 8'h44);
		// Reads: first in sleep with an ACKed last byte, then after
		// lost arbitration with a NACKed last byte.
		for (int k = 0; k < 2; k++) begin
			clk_stopped <= (k == 0);
			sel({own, 1'b1}, k == 1, 1'b1, k ? ST_ARB_R : ST_OWN_R);
			chk(8'(wake), 8'(k == 0));
			clk_stopped <= 1'b0;
			d = 8'(xs());
			wr(ADDR_DATA, d);
			wr(ADDR_CTL, 8'hC4);
			u_master.xfer(8'hFF, 1'b0, q, a);
			chk(q, d);
			wait_irq();
			rd(ADDR_STAT, ST_TX_ACK);
			d = 8'(xs());
			wr(ADDR_DATA, d);
			wr(ADDR_CTL, 8'h84);
			u_master.xfer(8'hFF, 1'(k), q, a);
			chk(q, d);
			wait_irq();
			rd(ADDR_STAT, k ? ST_TX_NACK : ST_TX_LAST);
			wr(ADDR_CTL, 8'hC4);
			u_master.xfer(8'hFF, 1'b1, q, a);
			chk(q, 8'hFF);
			u_master.stop();
		end
		// Isolated by ack_enable, then a foreign address.
		wr(ADDR_CTL, 8'h04);
		sel({own, 1'b1}, 1'b0, 1'b0, ST_NONE);
		u_master.stop();
		wr(ADDR_CTL, 8'h44);
		sel({own ^ 7'h01, 1'b0}, 1'b0, 1'b0, ST_NONE);
		u_master.stop();
		rd(ADDR_STAT, ST_NONE);
		// Stop while addressed, then a requested start on a free bus.
		sel({own, 1'b0}, 1'b0, 1'b1, ST_OWN_W);
		wr(ADDR_STAT, 8'h03);
		rd(ADDR_STAT, ST_OWN_W | 8'h03);
		wr(ADDR_STAT, 8'h00);
		wr(ADDR_CTL, 8'hC4);
		u_master.stop();
		wait_irq();
		rd(ADDR_STAT, ST_STOP);
		wr(ADDR_CTL, 8'hE4);
		wait_irq();
		rd(ADDR_STAT, ST_START);
		wr(ADDR_CTL, 8'hD4);
		rd(ADDR_CTL, 8'h44);
		// General call data: ACK, then NACK, then clocks ignored.
		sel(8'h00, 1'b0, 1'b1, ST_GC_W);
		wr(ADDR_CTL, 8'hC4);
		d = 8'(xs());
		u_master.xfer(d, 1'b1, q, a);
		chk(8'(a), 8'h00);
		wait_irq();
		rd(ADDR_STAT, ST_GC_ACK);
		rd(ADDR_DATA, d);
		wr(ADDR_CTL, 8'h84);
		u_master.xfer(8'(xs()), 1'b1, q, a);
		chk(8'(a), 8'h01);
		wait_irq();
		rd(ADDR_STAT, ST_GC_NACK);
		wr(ADDR_CTL, 8'hC4);
		u_master.xfer(8'h00, 1'b1, q, a);
		chk(8'(a), 8'h01);
		u_master.stop();
		wr(ADDR_OWN, {own, 1'b0});
		sel(8'h00, 1'b0, 1'b0, ST_NONE);
		u_master.stop();
		chk(8'(u_master.hangs), 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
